// File: verilog/fabi_host.sv
// Host controller driving an asynchronous flash over its pins.
// Assumes the user holds request fields while REQ_VALID waits for REQ_READY.
`timescale 1ns/1ns
module fabi_host
   import fabi_pkg::*;
(
   // Clock and reset
   input  wire logic                        REF_CLK,
   input  wire logic                        RST_N,
   // User request
   input  wire logic                        REQ_VALID,
   output logic                             REQ_READY,
   input  wire fabi_pkg::fabi_op_e          REQ_OP,
   input  wire logic [fabi_pkg::ADDR_W:0]   REQ_ADDR,
   input  wire logic [fabi_pkg::DATA_W-1:0] REQ_WDATA,
   // User response
   output logic                             RSP_VALID,
   output logic      [fabi_pkg::DATA_W-1:0] RSP_RDATA,
   // Flash control pins
   output logic                             FLASH_CE_N,
   output logic                             FLASH_OE_N,
   output logic                             FLASH_WE_N,
   output logic      [fabi_pkg::ADDR_W-1:0] FLASH_ADDR,
   output logic                             FLASH_BANK_HALF_SELECT,
   output logic                             FLASH_ID_HV_EN,
   // Flash data lines
   input  wire logic [fabi_pkg::DATA_W-1:0] FLASH_DATA_LINES_I,
   output logic      [fabi_pkg::DATA_W-1:0] FLASH_DATA_LINES_O,
   output logic                             FLASH_DATA_LINES_OE
);

   // Sequencer phases
   typedef enum logic [1:0] {SQ_IDLE, SQ_ISSUE, SQ_WAIT} fabi_sq_e;

   logic                rs1_reg, rs2_reg;      // Reset release synchroniser
   logic                rst_n;                 // Internal reset
   fabi_sq_e            st_reg, st_next;       // Sequencer phase
   fabi_op_e            op_reg, op_next;       // Operation in hand
   logic [ADDR_W:0]     ua_reg, ua_next;       // User address, bit 0 is half select
   logic [DATA_W-1:0]   ud_reg, ud_next;       // User data
   logic [2:0]          k_reg, k_next;         // Step within sequence
   logic                hv_reg, hv_next;       // Identifier voltage request
   logic                rv_reg, rv_next;       // Response pulse
   logic [DATA_W-1:0]   rd_reg, rd_next;       // Response data
   logic                cy_start;              // Launch one bus cycle
   logic                cy_idle;               // Bus engine free
   logic                cy_done;               // Bus cycle finished
   logic [DATA_W-1:0]   cy_rdata;              // Bus read data
   logic [ADDR_W:0]     step_a;                // Step address with half select
   logic [DATA_W-1:0]   step_d;                // Step data

   // Number of bus cycles an operation takes
   function automatic logic [2:0] step_total(input fabi_op_e op);
      case (op)
         OP_READ, OP_ID_HV:                 step_total = 3'h1;
         OP_READ_RESET:                     step_total = 3'h3;
         OP_PROGRAM, OP_ID_CMD, OP_STATUS:  step_total = 3'h4;
         default:                           step_total = 3'h6;
      endcase
   endfunction

   // Whether a step is a read cycle
   function automatic logic step_is_rd(input fabi_op_e op, input logic [2:0] k);
      step_is_rd = (op == OP_READ) || (op == OP_ID_HV) ||
                   (((op == OP_ID_CMD) || (op == OP_STATUS)) && (k == STEP_FOUR));
   endfunction

   // Address and half select of a step; upper bits of unlock and command steps are don't care, driven low
   function automatic logic [ADDR_W:0] step_addr(input fabi_op_e op, input logic [2:0] k,
                                                  input logic [ADDR_W:0] ua);
      logic [14:0] ul;
      ul = ((k == 3'h1) || (k == 3'h4)) ? UNLOCK_ADDR2 : UNLOCK_ADDR1;
      step_addr = {5'h0, ul, 1'b0};
      case (op)
         OP_READ:
            step_addr = ua;
         OP_ID_HV:
            step_addr = {19'h0, ua[1], 1'b0};
         OP_PROGRAM:
            if (k == STEP_FOUR)
               step_addr = ua;
         OP_SECTOR_ERASE:
            if (k == STEP_SIXTH)
               step_addr = {ua[ADDR_W:1], 1'b0};
         OP_ID_CMD:
            if (k == STEP_FOUR)
               step_addr = {19'h0, ua[1], 1'b0};
         OP_STATUS:
            if (k == STEP_FOUR)
               step_addr = '0;
         default:
            step_addr = {5'h0, ul, 1'b0};
      endcase
   endfunction

   // Data byte written at a step
   function automatic logic [DATA_W-1:0] step_data(input fabi_op_e op, input logic [2:0] k,
                                                    input logic [DATA_W-1:0] ud);
      case (k)
         3'h0, 3'h3: step_data = CMD_UNLOCK_A;
         3'h1, 3'h4: step_data = CMD_UNLOCK_B;
         3'h5:       step_data = (op == OP_CHIP_ERASE) ? CMD_CHIP_ERASE : CMD_SECTOR_ERASE;
         default:
            case (op)
               OP_PROGRAM:    step_data = CMD_PROGRAM;
               OP_READ_RESET: step_data = CMD_READ_RESET;
               OP_ID_CMD:     step_data = CMD_ID_READ;
               OP_STATUS:     step_data = CMD_STATUS_READ;
               default:       step_data = CMD_ERASE_SETUP;
            endcase
      endcase
      // The program data rides the fourth write
      if ((op == OP_PROGRAM) && (k == STEP_FOUR))
         step_data = ud;
   endfunction

   // Reset released through two flip-flops
   always_ff @(posedge REF_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         rs1_reg <= 1'b0;
         rs2_reg <= 1'b0;
      end
      else
      begin
         rs1_reg <= 1'b1;
         rs2_reg <= rs1_reg;
      end
   end
   assign rst_n = rs2_reg;

   assign step_a = step_addr(op_reg, k_reg, ua_reg);
   assign step_d = step_data(op_reg, k_reg, ud_reg);

   // Sequencer next state
   always_comb
   begin
      st_next  = st_reg;
      op_next  = op_reg;
      ua_next  = ua_reg;
      ud_next  = ud_reg;
      k_next   = k_reg;
      hv_next  = hv_reg;
      rv_next  = 1'b0;
      rd_next  = rd_reg;
      cy_start = 1'b0;
      case (st_reg)
         SQ_IDLE:
         begin
            if (REQ_VALID)
            begin
               op_next = REQ_OP;
               ua_next = REQ_ADDR;
               ud_next = REQ_WDATA;
               k_next  = '0;
               // Raise identifier voltage for the whole read
               hv_next = (REQ_OP == OP_ID_HV);
               st_next = SQ_ISSUE;
            end
         end
         SQ_ISSUE:
         begin
            if (cy_idle)
            begin
               cy_start = 1'b1;
               st_next  = SQ_WAIT;
            end
         end
         SQ_WAIT:
         begin
            if (cy_done)
            begin
               // Finish only after every step issued
               if (k_reg == step_total(op_reg) - 3'h1)
               begin
                  rv_next = 1'b1;
                  rd_next = step_is_rd(op_reg, k_reg) ? cy_rdata : '0;
                  hv_next = 1'b0;
                  st_next = SQ_IDLE;
               end
               else
               begin
                  k_next  = k_reg + 3'h1;
                  st_next = SQ_ISSUE;
               end
            end
         end
         default:
            st_next = SQ_IDLE;
      endcase
   end

   // Sequencer registers
   always_ff @(posedge REF_CLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_reg <= SQ_IDLE;
         op_reg <= OP_READ;
         ua_reg <= '0;
         ud_reg <= '0;
         k_reg  <= '0;
         hv_reg <= 1'b0;
         rv_reg <= 1'b0;
         rd_reg <= '0;
      end
      else
      begin
         st_reg <= st_next;
         op_reg <= op_next;
         ua_reg <= ua_next;
         ud_reg <= ud_next;
         k_reg  <= k_next;
         hv_reg <= hv_next;
         rv_reg <= rv_next;
         rd_reg <= rd_next;
      end
   end

   fabi_cycle u_cycle (
      .clk      (REF_CLK),
      .rst_n    (rst_n),
      .start    (cy_start),
      .is_wr    (!step_is_rd(op_reg, k_reg)),
      .addr     (step_a[ADDR_W:1]),
      .bsel     (step_a[0]),
      .wdata    (step_d),
      .idle     (cy_idle),
      .done     (cy_done),
      .rdata    (cy_rdata),
      .ce_n     (FLASH_CE_N),
      .oe_n     (FLASH_OE_N),
      .we_n     (FLASH_WE_N),
      .pin_addr (FLASH_ADDR),
      .pin_bsel (FLASH_BANK_HALF_SELECT),
      .dq_in    (FLASH_DATA_LINES_I),
      .dq_out   (FLASH_DATA_LINES_O),
      .dq_oe    (FLASH_DATA_LINES_OE)
   );

   // Outputs; no request is taken while a sequence runs
   assign REQ_READY      = rst_n && (st_reg == SQ_IDLE);
   assign RSP_VALID      = rv_reg;
   assign RSP_RDATA      = rd_reg;
   assign FLASH_ID_HV_EN = hv_reg;

   // Helper: write strobes since the operation was taken
   logic [2:0] wcnt_reg;
   always_ff @(posedge REF_CLK or negedge rst_n)
   begin
      if (!rst_n)
         wcnt_reg <= '0;
      else if (REQ_READY && REQ_VALID)
         wcnt_reg <= '0;
      else if ($fell(FLASH_WE_N))
         wcnt_reg <= wcnt_reg + 3'h1;
   end

   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!rst_n);

   chk_strobe_exclusive: assert property (!(!FLASH_OE_N && !FLASH_WE_N))
      else $error("Both strobes low together");
   chk_write_pins: assert property (!FLASH_WE_N |-> !FLASH_CE_N && FLASH_OE_N && FLASH_DATA_LINES_OE)
      else $error("Write strobe without proper pin levels");
   chk_read_select: assert property (!FLASH_OE_N |-> !FLASH_CE_N && !FLASH_DATA_LINES_OE)
      else $error("Read without chip select or with data driven");
   chk_ce_release: assert property ($rose(FLASH_CE_N) |-> $past(FLASH_OE_N, 2) && $past(FLASH_WE_N, 2))
      else $error("Chip enable rose while a strobe was active");
   chk_id_pins: assert property ((op_reg == OP_ID_HV) && $fell(FLASH_OE_N) |->
                                 FLASH_ID_HV_EN && !FLASH_ADDR[1] && !FLASH_BANK_HALF_SELECT)
      else $error("Identifier read pins wrong");
   chk_read_lsb: assert property ((op_reg == OP_READ) && $fell(FLASH_OE_N) |->
                                  ({FLASH_ADDR, FLASH_BANK_HALF_SELECT} == ua_reg))
      else $error("Read address or half select wrong");
   chk_unlock_first: assert property ((op_reg != OP_READ) && (op_reg != OP_ID_HV) && (k_reg == 3'h0) &&
                                      $fell(FLASH_WE_N) |->
                                      (FLASH_ADDR[14:0] == UNLOCK_ADDR1) && (FLASH_DATA_LINES_O == CMD_UNLOCK_A))
      else $error("Sequence did not open with unlock write");
   chk_program_seq: assert property ((op_reg == OP_PROGRAM) && (k_reg == STEP_FOUR) && $fell(FLASH_WE_N) |->
                                     (wcnt_reg == 3'h3) && (FLASH_DATA_LINES_O == ud_reg))
      else $error("Program data write not preceded by three writes");
   chk_rsp_bound: assert property (cy_done && (st_reg == SQ_WAIT) && (k_reg == step_total(op_reg) - 3'h1)
                                   |=> RSP_VALID ##1 REQ_READY)
      else $error("Response not given after last step");

   cov_read: cover property ((op_reg == OP_READ) && RSP_VALID);
   cov_program: cover property ((op_reg == OP_PROGRAM) && RSP_VALID);
   cov_id_hv: cover property ((op_reg == OP_ID_HV) && RSP_VALID);
   cov_sector_erase: cover property ((op_reg == OP_SECTOR_ERASE) && RSP_VALID);

endmodule

// File: verilog/fabi_pkg.sv
// Shared constants for the flash bus host controller.
// Assumes a 250 MHz host clock and an 8-bit flash data path.
package fabi_pkg;

   // Host clock period in ns
   localparam int CLK_PERIOD_NS   = 4;
   // Pin timing, figures in ns (plain defaults, tune per speed grade)
   localparam int T_SETUP_NS      = 10;
   localparam int T_WE_PULSE_NS   = 60;
   localparam int T_RD_ACCESS_NS  = 160;
   localparam int T_HOLD_NS       = 10;
   // Least times round up to whole cycles
   localparam int SETUP_CYC       = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WE_PULSE_CYC    = (T_WE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RD_ACCESS_CYC   = (T_RD_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HOLD_CYC        = (T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Flip-flops on the data input path
   localparam int SYNC_STAGES     = 2;
   // Cycle counter width
   localparam int CNT_W           = 8;

   // Pin widths
   localparam int ADDR_W          = 20;
   localparam int DATA_W          = 8;

   // Unlock addresses on the low fifteen address bits
   localparam logic [14:0] UNLOCK_ADDR1 = 15'h5555;
   localparam logic [14:0] UNLOCK_ADDR2 = 15'h2aaa;
   // Command bytes
   localparam logic [7:0] CMD_UNLOCK_A     = 8'haa;
   localparam logic [7:0] CMD_UNLOCK_B     = 8'h55;
   localparam logic [7:0] CMD_READ_RESET   = 8'hf0;
   localparam logic [7:0] CMD_ID_READ      = 8'h90;
   localparam logic [7:0] CMD_PROGRAM      = 8'ha0;
   localparam logic [7:0] CMD_ERASE_SETUP  = 8'h80;
   localparam logic [7:0] CMD_CHIP_ERASE   = 8'h10;
   localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
   localparam logic [7:0] CMD_STATUS_READ  = 8'h70;

   // Step positions inside a command sequence
   localparam logic [2:0] STEP_CMD   = 3'h2;
   localparam logic [2:0] STEP_FOUR  = 3'h3;
   localparam logic [2:0] STEP_SIXTH = 3'h5;

   // Operations the user side can request
   typedef enum logic [2:0] {
      OP_READ,
      OP_PROGRAM,
      OP_CHIP_ERASE,
      OP_SECTOR_ERASE,
      OP_READ_RESET,
      OP_ID_CMD,
      OP_ID_HV,
      OP_STATUS
   } fabi_op_e;

endpackage

// File: verilog/fabi_cycle.sv
// One asynchronous flash bus cycle: setup, strobe, hold.
// Assumes start only while idle; dq_in comes straight from the pins.
`timescale 1ns/1ns
module fabi_cycle
   import fabi_pkg::*;
(
   // Clock and reset
   input  wire logic                        clk,
   input  wire logic                        rst_n,
   // Cycle request
   input  wire logic                        start,
   input  wire logic                        is_wr,
   input  wire logic [fabi_pkg::ADDR_W-1:0] addr,
   input  wire logic                        bsel,
   input  wire logic [fabi_pkg::DATA_W-1:0] wdata,
   output logic                             idle,
   output logic                             done,
   output logic      [fabi_pkg::DATA_W-1:0] rdata,
   // Flash pins
   output logic                             ce_n,
   output logic                             oe_n,
   output logic                             we_n,
   output logic      [fabi_pkg::ADDR_W-1:0] pin_addr,
   output logic                             pin_bsel,
   input  wire logic [fabi_pkg::DATA_W-1:0] dq_in,
   output logic      [fabi_pkg::DATA_W-1:0] dq_out,
   output logic                             dq_oe
);

   // Cycle phases
   typedef enum logic [1:0] {CY_IDLE, CY_SETUP, CY_STROBE, CY_HOLD} fabi_cy_e;

   fabi_cy_e              st_reg, st_next;     // Phase
   logic [CNT_W-1:0]      cnt_reg, cnt_next;   // Cycles left in phase
   logic                  wr_reg, wr_next;     // Cycle is a write
   logic                  ce_reg, ce_next;     // Chip enable, low active
   logic                  oe_reg, oe_next;     // Output enable, low active
   logic                  we_reg, we_next;     // Write enable, low active
   logic [ADDR_W-1:0]     a_reg, a_next;       // Address on pins
   logic                  b_reg, b_next;       // Bank half select
   logic [DATA_W-1:0]     d_reg, d_next;       // Write data
   logic                  doe_reg, doe_next;   // Data drive
   logic [DATA_W-1:0]     rd_reg, rd_next;     // Captured read data
   logic                  dn_reg, dn_next;     // Done pulse
   logic [DATA_W-1:0]     s1_reg, s2_reg;      // Data input synchroniser

   // Pin data is asynchronous; only s2 is ever looked at
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s1_reg <= '0;
         s2_reg <= '0;
      end
      else
      begin
         s1_reg <= dq_in;
         s2_reg <= s1_reg;
      end
   end

   // Next-state of the bus cycle
   always_comb
   begin
      st_next  = st_reg;
      cnt_next = cnt_reg;
      wr_next  = wr_reg;
      ce_next  = ce_reg;
      oe_next  = oe_reg;
      we_next  = we_reg;
      a_next   = a_reg;
      b_next   = b_reg;
      d_next   = d_reg;
      doe_next = doe_reg;
      rd_next  = rd_reg;
      dn_next  = 1'b0;
      case (st_reg)
         CY_IDLE:
         begin
            // Select chip, present address and data, strobes stay high
            if (start)
            begin
               wr_next  = is_wr;
               ce_next  = 1'b0;
               a_next   = addr;
               b_next   = bsel;
               d_next   = wdata;
               doe_next = is_wr;
               cnt_next = CNT_W'(SETUP_CYC - 1);
               st_next  = CY_SETUP;
            end
         end
         CY_SETUP:
         begin
            if (cnt_reg == '0)
            begin
               // Only one strobe ever goes low, so host data never fights the device
               if (wr_reg)
               begin
                  we_next  = 1'b0;
                  cnt_next = CNT_W'(WE_PULSE_CYC - 1);
               end
               else
               begin
                  oe_next  = 1'b0;
                  cnt_next = CNT_W'(RD_ACCESS_CYC + SYNC_STAGES - 1);
               end
               st_next = CY_STROBE;
            end
            else
               cnt_next = cnt_reg - 1'b1;
         end
         CY_STROBE:
         begin
            if (cnt_reg == '0)
            begin
               // Extra sync cycles cover the two-stage input path
               if (!wr_reg)
                  rd_next = s2_reg;
               we_next  = 1'b1;
               oe_next  = 1'b1;
               cnt_next = CNT_W'(HOLD_CYC - 1);
               st_next  = CY_HOLD;
            end
            else
               cnt_next = cnt_reg - 1'b1;
         end
         CY_HOLD:
         begin
            // Data held past the rising write strobe, then deselect
            if (cnt_reg == '0)
            begin
               ce_next  = 1'b1;
               doe_next = 1'b0;
               dn_next  = 1'b1;
               st_next  = CY_IDLE;
            end
            else
               cnt_next = cnt_reg - 1'b1;
         end
         default:
            st_next = CY_IDLE;
      endcase
   end

   // Cycle registers
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_reg  <= CY_IDLE;
         cnt_reg <= '0;
         wr_reg  <= 1'b0;
         ce_reg  <= 1'b1;
         oe_reg  <= 1'b1;
         we_reg  <= 1'b1;
         a_reg   <= '0;
         b_reg   <= 1'b0;
         d_reg   <= '0;
         doe_reg <= 1'b0;
         rd_reg  <= '0;
         dn_reg  <= 1'b0;
      end
      else
      begin
         st_reg  <= st_next;
         cnt_reg <= cnt_next;
         wr_reg  <= wr_next;
         ce_reg  <= ce_next;
         oe_reg  <= oe_next;
         we_reg  <= we_next;
         a_reg   <= a_next;
         b_reg   <= b_next;
         d_reg   <= d_next;
         doe_reg <= doe_next;
         rd_reg  <= rd_next;
         dn_reg  <= dn_next;
      end
   end

   // Outputs
   assign idle     = (st_reg == CY_IDLE);
   assign done     = dn_reg;
   assign rdata    = rd_reg;
   assign ce_n     = ce_reg;
   assign oe_n     = oe_reg;
   assign we_n     = we_reg;
   assign pin_addr = a_reg;
   assign pin_bsel = b_reg;
   assign dq_out   = d_reg;
   assign dq_oe    = doe_reg;

endmodule

// File: bench/fabi_flash_model.sv
// Behavioural flash device as seen from its pins.
// Assumes the host moves its pins only just after its own clock edges.
`timescale 1ns/1ns
module fabi_flash_model
#(
   parameter logic [7:0] MFR_CODE = 8'h3c, // Arbitrary value
   parameter logic [7:0] DEV_CODE = 8'h5a  // Arbitrary value
)
(
   // Control pins
   input  wire logic        ce_n,
   input  wire logic        oe_n,
   input  wire logic        we_n,
   input  wire logic [19:0] addr,
   input  wire logic        bsel,
   input  wire logic        hv_en,
   // Data lines and overlap flag
   input  wire logic [7:0]  din,
   output logic      [7:0]  dout,
   output logic             viol
);
   logic [7:0]  mem [logic [20:0]]; // Programmed bytes only
   logic [19:0] wa;                 // Latched write address
   logic        wb;                 // Latched half select
   logic [1:0]  step;               // Unlock progress
   logic [1:0]  mode;               // 0 array, 1 ident, 2 status
   logic        prog;               // Next write programs
   logic        ers;                // Erase armed
   logic [7:0]  rd;                 // Selected read value
   logic [7:0]  last;               // Last driven value
   initial
   begin
      mode = 2'd0;
      step = 2'd0;
      prog = 1'b0;
      ers  = 1'b0;
      viol = 1'b0;
      last = 8'h00;
   end
   always @(negedge oe_n or negedge we_n)
      if (!oe_n && !we_n) viol = 1'b1;
   always @(negedge we_n)
      if (!ce_n)
      begin
         wa = addr;
         wb = bsel;
      end
   always @(posedge we_n)
      if (!ce_n)
      begin
         if (prog)
         begin
            mem[{wa, wb}] = din;
            prog = 1'b0;
            mode = 2'd2;
         end
         else if (step == 2'd0) step = (wa[14:0] == 15'h5555 && din == 8'haa) ? 2'd1 : 2'd0;
         else if (step == 2'd1) step = (wa[14:0] == 15'h2aaa && din == 8'h55) ? 2'd2 : 2'd0;
         else
         begin
            step = 2'd0;
            // Sector erase wipes all: coarser than real, never kinder
            if (ers && (din == 8'h10 || din == 8'h30))
            begin
               mem.delete();
               ers  = 1'b0;
               mode = 2'd2;
            end
            else if (din == 8'h80) ers = 1'b1;
            else if (din == 8'ha0) prog = 1'b1;
            else mode = (din == 8'h90) ? 2'd1 : (din == 8'h70) ? 2'd2 : 2'd0;
         end
      end
   // Read source by mode and address
   always @*
   begin
      if (mode == 2'd1 || (hv_en && !addr[1] && !bsel)) rd = addr[0] ? DEV_CODE : MFR_CODE;
      else if (mode == 2'd2) rd = 8'h80;
      else if (mem.exists({addr, bsel})) rd = mem[{addr, bsel}];
      else rd = {addr[6:0], bsel} ^ 8'ha5;
   end
   // Read value only in a selected read, else the inverse of the last one
   always @(ce_n, oe_n, we_n, rd)
      if (!ce_n && !oe_n && we_n)
      begin
         dout = rd;
         last = rd;
      end
      else dout = ~last;
endmodule

// File: bench/fabi_host_tb_top.sv
// Self-checking bench for the flash bus host controller.
// Assumes the behavioural flash model stands on the pins.
`timescale 1ns/1ns
module fabi_host_tb_top;
   import fabi_pkg::*;
   localparam logic [7:0]  MFR = 8'h3c;    // Arbitrary value
   localparam logic [7:0]  DEV = 8'h5a;    // Arbitrary value
   localparam logic [20:0] PA  = 21'h0a6b3; // Program target
   logic        REF_CLK, RST_N, req_valid, req_ready, rsp_valid;
   logic        ce_n, oe_n, we_n, bsel, hv_en, dq_oe, viol;
   fabi_op_e    req_op;
   logic [20:0] req_addr;
   logic [19:0] faddr;
   logic [7:0]  req_wdata, rsp_rdata, dq_o, dq_i, dev_dq, rd;
   int          bad_count, compares, cyc;
   // Wire level: host drive wins while enabled
   assign dq_i = dq_oe ? dq_o : dev_dq;
   fabi_host dut (.REF_CLK(REF_CLK), .RST_N(RST_N), .REQ_VALID(req_valid), .REQ_READY(req_ready),
      .REQ_OP(req_op), .REQ_ADDR(req_addr), .REQ_WDATA(req_wdata), .RSP_VALID(rsp_valid),
      .RSP_RDATA(rsp_rdata), .FLASH_CE_N(ce_n), .FLASH_OE_N(oe_n), .FLASH_WE_N(we_n),
      .FLASH_ADDR(faddr), .FLASH_BANK_HALF_SELECT(bsel), .FLASH_ID_HV_EN(hv_en),
      .FLASH_DATA_LINES_I(dq_i), .FLASH_DATA_LINES_O(dq_o), .FLASH_DATA_LINES_OE(dq_oe));
   fabi_flash_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) dev (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
      .addr(faddr), .bsel(bsel), .hv_en(hv_en), .din(dq_i), .dout(dev_dq), .viol(viol));
   // Free-running 250 MHz clock
   initial
   begin
      REF_CLK = 1'b0;
      forever #2 REF_CLK = ~REF_CLK;
   end
   task check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task print_verdict();
      $display("checks %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // One request, held until taken, then bounded wait for the answer
   task op(input fabi_op_e o, input logic [20:0] a, input logic [7:0] wd);
      int n;
      n = 0;
      @(posedge REF_CLK);
      req_valid <= 1'b1;
      req_op    <= o;
      req_addr  <= a;
      req_wdata <= wd;
      do @(negedge REF_CLK); while (req_ready !== 1'b1 && ++n < 500);
      @(posedge REF_CLK);
      req_valid <= 1'b0;
      while (rsp_valid !== 1'b1 && n < 900)
      begin
         @(negedge REF_CLK);
         n++;
      end
      rd = rsp_rdata;
      if (n >= 900) check("rsp_wait", 8'h00, 8'h01);
   endtask
   // Unwritten cells read as a pattern of address and half select
   function automatic logic [7:0] dflt(input logic [20:0] a);
      return a[7:0] ^ 8'ha5;
   endfunction
   task t_read_banks();
      op(OP_READ, 21'h00011, 8'h00);
      check("read_upper", rd, dflt(21'h00011));
      op(OP_READ, 21'h00010, 8'h00);
      check("read_lower", rd, dflt(21'h00010));
      check("ce_idle", {7'h00, ce_n}, 8'h01);
   endtask
   task t_program();
      op(OP_PROGRAM, PA, 8'h3e);
      check("prog_rsp", rd, 8'h00);
      op(OP_STATUS, 21'h0, 8'h00);
      check("status", rd, 8'h80);
      op(OP_READ_RESET, 21'h0, 8'h00);
      op(OP_READ, PA, 8'h00);
      check("prog_back", rd, 8'h3e);
      op(OP_READ, PA ^ 21'h1, 8'h00);
      check("other_half", rd, dflt(PA ^ 21'h1));
   endtask
   task t_erase();
      op(OP_SECTOR_ERASE, PA, 8'h00);
      op(OP_READ_RESET, 21'h0, 8'h00);
      op(OP_READ, PA, 8'h00);
      check("sector_erase", rd, dflt(PA));
      op(OP_PROGRAM, PA, 8'hc7);
      op(OP_CHIP_ERASE, 21'h0, 8'h00);
      op(OP_READ_RESET, 21'h0, 8'h00);
      op(OP_READ, PA, 8'h00);
      check("chip_erase", rd, dflt(PA));
   endtask
   task t_ident();
      op(OP_ID_CMD, 21'h0, 8'h00);
      check("id_cmd_mfr", rd, MFR);
      op(OP_ID_CMD, 21'h2, 8'h00);
      check("id_cmd_dev", rd, DEV);
      op(OP_READ_RESET, 21'h0, 8'h00);
      op(OP_ID_HV, 21'h0, 8'h00);
      check("id_hv_mfr", rd, MFR);
      op(OP_ID_HV, 21'h2, 8'h00);
      check("id_hv_dev", rd, DEV);
      check("hv_off", {7'h00, hv_en}, 8'h00);
      op(OP_READ, 21'h00044, 8'h00);
      check("array_after_id", rd, dflt(21'h00044));
   endtask
   // Hang guard well above the expected run
   always @(posedge REF_CLK)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         bad_count++;
         print_verdict();
      end
   end
   initial
   begin
      RST_N     = 1'b0;
      req_valid = 1'b0;
      req_op    = OP_READ;
      req_addr  = 21'h0;
      req_wdata = 8'h00;
      bad_count = 0;
      compares  = 0;
      cyc       = 0;
      repeat (5) @(posedge REF_CLK);
      RST_N <= 1'b1;
      repeat (3) @(posedge REF_CLK);
      t_read_banks();
      t_program();
      t_erase();
      t_ident();
      check("strobe_overlap", {7'h00, viol}, 8'h00);
      print_verdict();
   end
endmodule
